// *** tbd_decoder.sv ***
`timescale 1ns/100ps
`default_nettype none
module tbd_decoder
    import tbd_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata,
    output var  tbd_nvm_t    nvm_cmd
);

    logic        addr_ph;
    logic        wr_pend_r;
    logic [2:0]  wa_r;
    logic        go_r;
    tbd_ctrl_t   ctrl_r;
    tbd_hdr_t    hdr_r;
    tbd_len_t    len_r;
    tbd_cfg_t    cfg_r;
    tbd_state_t  state_r;
    tbd_act_t    act_r;
    logic [15:0] sw_r;
    logic        swv_r;
    logic        done_r;
    logic [31:0] rd_mux;

    assign addr_ph = hsel & hready & htrans[1];

    // Address phase capture; only whole-word writes are stored.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wa_r      <= 3'h0;
        end else begin
            wr_pend_r <= addr_ph & hwrite & (hsize == HSIZE_WORD);
            if (addr_ph) begin
                wa_r <= haddr[4:2];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_comb begin
        case (haddr[4:2])
            IDX_CTRL: rd_mux = ctrl_r;
            IDX_HDR:  rd_mux = hdr_r;
            IDX_LEN:  rd_mux = len_r;
            IDX_CFG:  rd_mux = cfg_r;
            IDX_STAT: rd_mux = tbd_stat_t'{rsvd: 9'h000, done: done_r, swv: swv_r,
                                           state: state_r, act: act_r, sw: sw_r};
            default:  rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is fetched in the address phase so the data phase needs no wait.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ph && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= '0;
            go_r   <= 1'b0;
        end else begin
            go_r <= 1'b0;
            if (wr_pend_r && wa_r == IDX_CTRL) begin
                ctrl_r     <= hwdata;
                ctrl_r.go  <= 1'b0;
                ctrl_r.rsvd <= '0;
                go_r       <= hwdata[0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hdr_r <= '0;
            len_r <= '0;
            cfg_r <= CFG_RST;
        end else if (wr_pend_r) begin
            if (wa_r == IDX_HDR) begin
                hdr_r <= hwdata;
            end
            if (wa_r == IDX_LEN) begin
                len_r      <= hwdata;
                len_r.rsvd <= '0;
            end
            if (wa_r == IDX_CFG) begin
                cfg_r <= hwdata;
            end
        end
    end

    // APDU field view: b0 class, b1 instruction, b2 P1, b3 P2.
    logic       is_sel;
    logic       is_rd;
    logic       is_wr;
    logic [2:0] mode;
    logic       enc;
    logic       mode_ok;
    logic [11:0] addr;
    logic [7:0] dlen;
    logic       len_bad;
    logic [15:0] apdu_sw;

    assign is_sel = hdr_r.b1 == INS_SEL;
    assign is_rd  = hdr_r.b1 == INS_RD;
    assign is_wr  = hdr_r.b1 == INS_WR;
    assign mode   = hdr_r.b2[6:4];
    assign enc    = (mode == MODE_PRIV) || (mode == MODE_FAM);
    assign mode_ok = (mode == MODE_PLAIN) || enc;
    assign addr   = {hdr_r.b2[3:0], hdr_r.b3};
    assign dlen   = is_wr ? len_r.lc : len_r.le;

    // A read carries only Le, a write only a nonzero Lc.
    always_comb begin
        if (is_rd) begin
            len_bad = len_r.lc_pres || !len_r.le_pres;
        end else begin
            len_bad = !len_r.lc_pres || len_r.le_pres || (len_r.lc == 8'h00);
        end
        if (enc && (dlen[3:0] != 4'h0)) begin
            len_bad = 1'b1;
        end
    end

    // Checks run class, instruction, parameters, length, memory; first hit wins.
    always_comb begin
        if (hdr_r.b0 != CLA_OK) begin
            apdu_sw = SW_CLA;
        end else if (!(is_sel || is_rd || is_wr)) begin
            apdu_sw = SW_INS;
        end else if (is_sel) begin
            apdu_sw = len_r.lc_pres ? SW_OK : SW_LEN;
        end else if (hdr_r.b2[P1_LOCK_BIT]) begin
            apdu_sw = SW_PAR;
        end else if (!mode_ok) begin
            apdu_sw = SW_PAR;
        end else if (addr >= NVM_BYTES || (enc && addr[3:0] != 4'h0)) begin
            apdu_sw = SW_PAR;
        end else if (len_bad) begin
            apdu_sw = SW_LEN;
        end else if (is_wr && addr >= cfg_r.ro_base) begin
            apdu_sw = SW_SELF;
        end else if (!enc && addr >= cfg_r.enc_base) begin
            apdu_sw = SW_SELF;
        end else begin
            apdu_sw = SW_OK;
        end
    end

    // Identification frame view: b0 code, b1 family byte, b2 PARAM.
    logic afi_hit;
    logic wake;

    assign wake = hdr_r.b2[PARAM_WAKE];

    always_comb begin
        if (hdr_r.b1 == AFI_ALL) begin
            afi_hit = 1'b1;
        end else if (hdr_r.b1[3:0] == 4'h0) begin
            afi_hit = hdr_r.b1[7:4] == cfg_r.afi[7:4];
        end else if (hdr_r.b1[7:4] == 4'h0) begin
            afi_hit = hdr_r.b1[3:0] == cfg_r.afi[3:0];
        end else begin
            afi_hit = hdr_r.b1 == cfg_r.afi;
        end
    end

    tbd_act_t   d_act;
    tbd_state_t d_state;
    logic [15:0] d_sw;
    logic       d_swv;
    tbd_nvm_t   d_nvm;

    always_comb begin
        d_act   = ACT_NONE;
        d_state = state_r;
        d_sw    = SW_OK;
        d_swv   = 1'b0;
        d_nvm   = '0;
        case (ctrl_r.kind)
            FK_TYPEB: begin
                if (ctrl_r.crc_ok) begin
                    case (hdr_r.b0)
                        CMD_REQ: begin
                            if (afi_hit && (state_r == ST_IDLE || state_r == ST_READY ||
                                            (wake && state_r == ST_HALT))) begin
                                d_act   = ACT_ATQB;
                                d_state = ST_READY;
                            end
                        end
                        CMD_ATTR: begin
                            if (state_r == ST_READY) begin
                                d_act   = ACT_ATTRIB;
                                d_state = ST_ACTIVE;
                            end
                        end
                        CMD_HALT: begin
                            if (state_r == ST_READY || state_r == ST_ACTIVE) begin
                                d_act   = ACT_HALT;
                                d_state = ST_HALT;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            FK_IBLK: begin
                if (state_r == ST_ACTIVE) begin
                    if (ctrl_r.chain) begin
                        d_act = ACT_RACK;
                    end else begin
                        d_act = ACT_APDU;
                        d_swv = 1'b1;
                        d_sw  = apdu_sw;
                        if (apdu_sw == SW_OK && (is_rd || is_wr)) begin
                            d_nvm = '{valid: 1'b1, write: is_wr, encrypt: enc,
                                      fam_key: mode == MODE_FAM, addr: addr, len: dlen};
                        end
                    end
                end
            end
            FK_RBLK: begin
                if (state_r == ST_ACTIVE) begin
                    d_act = ACT_RESEND;
                end
            end
            FK_SBLK: begin
                if (state_r == ST_ACTIVE) begin
                    d_act   = ACT_DESEL;
                    d_state = ST_HALT;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_IDLE;
        end else if (go_r) begin
            state_r <= d_state;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_r  <= ACT_NONE;
            sw_r   <= SW_OK;
            swv_r  <= 1'b0;
            done_r <= 1'b0;
        end else if (go_r) begin
            act_r  <= d_act;
            sw_r   <= d_sw;
            swv_r  <= d_swv;
            done_r <= 1'b1;
        end else if (wr_pend_r && wa_r == IDX_CTRL) begin
            done_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nvm_cmd <= '0;
        end else if (go_r) begin
            nvm_cmd <= d_nvm;
        end else begin
            nvm_cmd.valid <= 1'b0;
        end
    end

    logic apdu_go;
    assign apdu_go = go_r && ctrl_r.kind == FK_IBLK && !ctrl_r.chain && state_r == ST_ACTIVE;

    property p_cla;
        @(posedge hclk) disable iff (!hresetn)
        apdu_go && hdr_r.b0 != CLA_OK |=> swv_r && sw_r == SW_CLA && act_r == ACT_APDU;
    endproperty
    a_cla: assert property (p_cla) else $error("class error not reported");

    property p_ins;
        @(posedge hclk) disable iff (!hresetn)
        apdu_go && hdr_r.b0 == CLA_OK && !(is_sel || is_rd || is_wr) |=> sw_r == SW_INS;
    endproperty
    a_ins: assert property (p_ins) else $error("instruction error not reported");

    property p_lock;
        @(posedge hclk) disable iff (!hresetn)
        apdu_go && hdr_r.b0 == CLA_OK && (is_rd || is_wr) && hdr_r.b2[7] |=> sw_r == SW_PAR;
    endproperty
    a_lock: assert property (p_lock) else $error("P1 bit 7 not rejected");

    property p_mode;
        @(posedge hclk) disable iff (!hresetn)
        apdu_go && hdr_r.b0 == CLA_OK && (is_rd || is_wr) && !hdr_r.b2[7] && !mode_ok
        |=> sw_r == SW_PAR && !nvm_cmd.valid;
    endproperty
    a_mode: assert property (p_mode) else $error("reserved mode not rejected");

    property p_okcmd;
        @(posedge hclk) disable iff (!hresetn)
        nvm_cmd.valid |-> $past(go_r) && sw_r == SW_OK && act_r == ACT_APDU;
    endproperty
    a_okcmd: assert property (p_okcmd) else $error("memory command without good status");

    property p_ro;
        @(posedge hclk) disable iff (!hresetn)
        nvm_cmd.valid && nvm_cmd.write |-> nvm_cmd.addr < cfg_r.ro_base;
    endproperty
    a_ro: assert property (p_ro) else $error("write reached read-only region");

    property p_encreg;
        @(posedge hclk) disable iff (!hresetn)
        nvm_cmd.valid && !nvm_cmd.encrypt |-> nvm_cmd.addr < cfg_r.enc_base;
    endproperty
    a_encreg: assert property (p_encreg) else $error("plaintext reached encrypted region");

    property p_align;
        @(posedge hclk) disable iff (!hresetn)
        nvm_cmd.valid && nvm_cmd.encrypt |-> nvm_cmd.addr[3:0] == 4'h0 &&
        nvm_cmd.len[3:0] == 4'h0 && nvm_cmd.addr < NVM_BYTES;
    endproperty
    a_align: assert property (p_align) else $error("encrypted access not aligned");

    property p_halt;
        @(posedge hclk) disable iff (!hresetn)
        go_r && ctrl_r.kind == FK_TYPEB && ctrl_r.crc_ok && hdr_r.b0 == CMD_HALT &&
        (state_r == ST_READY || state_r == ST_ACTIVE) |=> (state_r == ST_HALT) [*2];
    endproperty
    a_halt: assert property (p_halt) else $error("halt command not taken");

    property p_nowake;
        @(posedge hclk) disable iff (!hresetn)
        go_r && state_r == ST_HALT && ctrl_r.kind == FK_TYPEB && !wake
        |=> act_r == ACT_NONE && state_r == ST_HALT;
    endproperty
    a_nowake: assert property (p_nowake) else $error("halted tag answered a request");

    property p_attrib;
        @(posedge hclk) disable iff (!hresetn)
        go_r && ctrl_r.kind == FK_TYPEB && ctrl_r.crc_ok && hdr_r.b0 == CMD_ATTR &&
        state_r == ST_READY |=> state_r == ST_ACTIVE && act_r == ACT_ATTRIB;
    endproperty
    a_attrib: assert property (p_attrib) else $error("attribute command not taken");

    property p_crc;
        @(posedge hclk) disable iff (!hresetn)
        go_r && ctrl_r.kind == FK_TYPEB && !ctrl_r.crc_ok
        |=> $stable(state_r) && act_r == ACT_NONE;
    endproperty
    a_crc: assert property (p_crc) else $error("bad checksum frame not discarded");

endmodule : tbd_decoder
`default_nettype wire

// *** tbd_pkg.sv ***
package tbd_pkg;

    localparam logic [2:0] IDX_CTRL = 3'h0;
    localparam logic [2:0] IDX_HDR  = 3'h1;
    localparam logic [2:0] IDX_LEN  = 3'h2;
    localparam logic [2:0] IDX_CFG  = 3'h3;
    localparam logic [2:0] IDX_STAT = 3'h4;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    localparam logic [7:0] CMD_REQ  = 8'h05;
    localparam logic [7:0] CMD_ATTR = 8'h1d;
    localparam logic [7:0] CMD_HALT = 8'h50;
    localparam logic [7:0] CLA_OK   = 8'h00;
    localparam logic [7:0] INS_SEL  = 8'ha4;
    localparam logic [7:0] INS_RD   = 8'hb0;
    localparam logic [7:0] INS_WR   = 8'hd6;
    localparam logic [7:0] AFI_ALL  = 8'h00;

    localparam logic [15:0] SW_OK   = 16'h9000;
    localparam logic [15:0] SW_LEN  = 16'h6700;
    localparam logic [15:0] SW_PAR  = 16'h6a86;
    localparam logic [15:0] SW_INS  = 16'h6d00;
    localparam logic [15:0] SW_CLA  = 16'h6e00;
    localparam logic [15:0] SW_SELF = 16'h6f00;

    localparam logic [2:0] MODE_PLAIN = 3'h0;
    localparam logic [2:0] MODE_PRIV  = 3'h2;
    localparam logic [2:0] MODE_FAM   = 3'h3;
    localparam int P1_LOCK_BIT   = 7;
    localparam int PARAM_WAKE    = 3;
    localparam logic [11:0] NVM_BYTES = 12'h800;
    localparam logic [11:0] RO_RST    = 12'h800;
    localparam logic [11:0] ENC_RST   = 12'h800;
    localparam logic [7:0]  AFI_RST   = 8'h00;

    typedef enum logic [1:0] {FK_TYPEB, FK_IBLK, FK_RBLK, FK_SBLK} tbd_kind_t;
    typedef enum logic [1:0] {ST_IDLE, ST_READY, ST_ACTIVE, ST_HALT} tbd_state_t;
    typedef enum logic [2:0] {ACT_NONE, ACT_ATQB, ACT_ATTRIB, ACT_HALT, ACT_APDU,
                              ACT_RACK, ACT_RESEND, ACT_DESEL} tbd_act_t;

    typedef struct packed {
        logic [26:0] rsvd;
        logic        chain;
        logic        crc_ok;
        tbd_kind_t   kind;
        logic        go;
    } tbd_ctrl_t;

    typedef struct packed {
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
    } tbd_hdr_t;

    typedef struct packed {
        logic [13:0] rsvd;
        logic        le_pres;
        logic        lc_pres;
        logic [7:0]  le;
        logic [7:0]  lc;
    } tbd_len_t;

    typedef struct packed {
        logic [11:0] enc_base;
        logic [11:0] ro_base;
        logic [7:0]  afi;
    } tbd_cfg_t;

    typedef struct packed {
        logic [8:0]  rsvd;
        logic        done;
        logic        swv;
        tbd_state_t  state;
        tbd_act_t    act;
        logic [15:0] sw;
    } tbd_stat_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        encrypt;
        logic        fam_key;
        logic [11:0] addr;
        logic [7:0]  len;
    } tbd_nvm_t;

    localparam tbd_cfg_t CFG_RST = '{enc_base: ENC_RST, ro_base: RO_RST, afi: AFI_RST};

endpackage : tbd_pkg

// *** tbd_reader.sv ***
`timescale 1ns/100ps
`default_nettype none
module tbd_reader
    import tbd_pkg::*;
;
    function automatic logic [31:0] frame(input logic [7:0] code, afi, param);
        return {code, afi, param, 8'h00};
    endfunction : frame

    function automatic logic [31:0] ctl(input tbd_kind_t k, input logic crc, chn);
        return {27'h0, chn, crc, k, 1'b1};
    endfunction : ctl
endmodule : tbd_reader
`default_nettype wire

// *** tb_typeb_rfid_command_status_decoder.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_typeb_rfid_command_status_decoder
    import tbd_pkg::*;
;
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = '0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] hwdata  = '0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    tbd_nvm_t    nvm;
    tbd_nvm_t    nvm_last;
    int          failures = 0;
    int          checked  = 0;
    int          nvm_n    = 0;
    int          n0;
    logic [31:0] seed = 32'hfa536c8e;
    logic [31:0] rd;
    logic [31:0] r;
    logic [7:0]  cla, ins, p1, p2, lc, le;
    logic        lcp, lep, hit;
    logic [15:0] e;

    always #25 hclk = ~hclk;

    tbd_decoder DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .nvm_cmd(nvm));
    tbd_reader rdr ();

    always @(posedge hclk) begin
        if (nvm.valid === 1'b1) begin
            nvm_n++;
            nvm_last = nvm;
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs

    function automatic logic [15:0] model(input logic [7:0] c, i, p, q, l, t,
                                          input logic lp, tp);
        int   a;
        logic enc;
        a = {p[3:0], q};
        enc = p[6:4] == MODE_PRIV || p[6:4] == MODE_FAM;
        if (c != CLA_OK) return SW_CLA;
        if (i != INS_SEL && i != INS_RD && i != INS_WR) return SW_INS;
        if (i == INS_SEL) return lp ? SW_OK : SW_LEN;
        if (p[7] || (p[6:4] != MODE_PLAIN && !enc)) return SW_PAR;
        if (a >= NVM_BYTES || (enc && a[3:0] != 0)) return SW_PAR;
        if (i == INS_RD ? (!tp || lp || (enc && t[3:0] != 0))
                        : (!lp || tp || l == 0 || (enc && l[3:0] != 0))) return SW_LEN;
        if (i == INS_WR && a >= 'h600) return SW_SELF;
        if (!enc && a >= 'h700) return SW_SELF;
        return SW_OK;
    endfunction : model

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
        checked++;
        if (s !== x) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, x, s);
        end
    endtask : chk

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk("hresp", 32'h0, 32'(hresp));
    endtask : ahb

    task automatic run(input logic [31:0] c, input logic [31:0] h, input logic [31:0] l);
        int k;
        ahb(1'b1, 32'h4, h);
        ahb(1'b1, 32'h8, l);
        ahb(1'b1, 32'h0, c);
        k = 0;
        do begin
            ahb(1'b0, 32'h10, 32'h0);
            k++;
        end while (rd[22] !== 1'b1 && k < 20);
        chk("done", 32'h1, 32'(rd[22]));
    endtask : run

    task automatic tb(input tbd_kind_t k, input logic crc, input logic [31:0] h,
                      input tbd_act_t a, input tbd_state_t s);
        run(rdr.ctl(k, crc, 1'b0), h, 32'h0);
        chk("act", 32'(a), 32'(rd[18:16]));
        chk("state", 32'(s), 32'(rd[20:19]));
    endtask : tb

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #(50 * 20000);
        failures++;
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 32'h10, 32'h0);
        chk("stat_rst", 32'h00009000, rd);
        ahb(1'b0, 32'hc, 32'h0);
        chk("cfg_rst", 32'h80080000, rd);
        ahb(1'b1, 32'hc, 32'h70060035);
        ahb(1'b1, 32'h1c, 32'h12345678);
        ahb(1'b0, 32'h1c, 32'h0);
        chk("unmapped", 32'h0, rd);
        ahb(1'b0, 32'hc, 32'h0);
        chk("cfg", 32'h70060035, rd);
        $display("register test done");
        tb(FK_TYPEB, 1'b1, rdr.frame(CMD_HALT, 8'h0, 8'h0), ACT_NONE, ST_IDLE);
        tb(FK_IBLK, 1'b1, 32'h00b00000, ACT_NONE, ST_IDLE);
        tb(FK_TYPEB, 1'b1, rdr.frame(CMD_REQ, 8'h30, 8'he7), ACT_ATQB, ST_READY);
        tb(FK_TYPEB, 1'b1, rdr.frame(CMD_ATTR, 8'h0, 8'h0), ACT_ATTRIB, ST_ACTIVE);
        tb(FK_RBLK, 1'b1, 32'h0, ACT_RESEND, ST_ACTIVE);
        run(rdr.ctl(FK_IBLK, 1'b1, 1'b1), 32'h00b00000, 32'h0);
        chk("chain", 32'(ACT_RACK), 32'(rd[18:16]));
        $display("entry test done");
        repeat (150) begin
            seed = xs(seed);
            r = seed;
            cla = (r[3:0] == 4'h0) ? r[15:8] : CLA_OK;
            case (r[5:4])
                2'h0: ins = r[31:24];
                2'h1: ins = INS_SEL;
                2'h2: ins = INS_RD;
                default: ins = INS_WR;
            endcase
            seed = xs(seed);
            r = seed;
            p1 = {r[0] & r[1] & r[2], r[3] ? r[6:4] : 3'h0, r[7] & r[8], r[11:9]};
            p2 = r[12] ? {r[19:16], 4'h0} : r[19:12];
            lc = {r[23:20], r[24] ? 4'h0 : r[28:25]};
            le = {r[28:25], r[29] ? 4'h0 : r[23:20]};
            lcp = (ins != INS_RD) ^ (r[30] & r[31]);
            lep = (ins == INS_RD) ^ (r[29] & r[30]);
            e = model(cla, ins, p1, p2, lc, le, lcp, lep);
            n0 = nvm_n;
            run(rdr.ctl(FK_IBLK, 1'b1, 1'b0), {cla, ins, p1, p2}, {14'h0, lep, lcp, le, lc});
            chk("apdu_sw", 32'(e), 32'(rd[15:0]));
            chk("apdu", {1'b1, ACT_APDU, e}, {rd[21], rd[18:16], rd[15:0]});
            chk("apdu_swv", 32'h1, 32'(rd[21]));
            hit = e == SW_OK && ins != INS_SEL;
            chk("nvm_n", 32'(n0 + int'(hit)), 32'(nvm_n));
            if (hit) begin
                chk("nvm", {ins == INS_WR, p1[5], p1[6:4] == MODE_FAM, p1[3:0], p2},
                    {nvm_last.write, nvm_last.encrypt, nvm_last.fam_key,
                     nvm_last.addr});
                chk("nvm_len", 32'((ins == INS_WR) ? lc : le), 32'(nvm_last.len));
            end
        end
        $display("apdu test done");
        tb(FK_TYPEB, 1'b1, rdr.frame(CMD_HALT, 8'h0, 8'h0), ACT_HALT, ST_HALT);
        tb(FK_TYPEB, 1'b1, rdr.frame(CMD_REQ, 8'h0, 8'h0), ACT_NONE, ST_HALT);
        tb(FK_TYPEB, 1'b1, rdr.frame(CMD_REQ, 8'h36, 8'h08), ACT_NONE, ST_HALT);
        tb(FK_TYPEB, 1'b0, rdr.frame(CMD_REQ, 8'h35, 8'h08), ACT_NONE, ST_HALT);
        tb(FK_TYPEB, 1'b1, rdr.frame(CMD_REQ, 8'h35, 8'h0d), ACT_ATQB, ST_READY);
        tb(FK_TYPEB, 1'b1, rdr.frame(CMD_REQ, 8'h05, 8'h00), ACT_ATQB, ST_READY);
        tb(FK_TYPEB, 1'b1, rdr.frame(CMD_REQ, 8'h04, 8'h00), ACT_NONE, ST_READY);
        tb(FK_TYPEB, 1'b1, rdr.frame(CMD_ATTR, 8'h0, 8'h0), ACT_ATTRIB, ST_ACTIVE);
        tb(FK_SBLK, 1'b1, 32'h0, ACT_DESEL, ST_HALT);
        $display("halt test done");
        print_verdict();
    end
endmodule : tb_typeb_rfid_command_status_decoder
`default_nettype wire
